// [cpu_execute_rotate_sub_xor_sleep.sv]
`timescale 1ns/1ps

// Summary of operation
// - Rotate left through carry, old bit7 to carry
// - Rotate right through carry, only carry changes
// - Destination bit zero: accumulator; one: file
// - Sleep clears watchdog counter and prescaler
// - Sleep clears powerdown, sets timeout, nothing else
// - Sleep halts oscillator in low-power state
// - Return pops stack head into instruction pointer
// - Return takes two cycles, prefetch discarded
// - Literal minus accumulator, updates three flags
// - File minus accumulator to destination, three flags
// - Nibble exchange to destination, no flags
// - Literal xor accumulator, only null flag
// - File xor accumulator to destination, null flag
module cpu_execute_rotate_sub_xor_sleep (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [exec_pkg::APB_AW-1:0] paddr,
	input wire logic [exec_pkg::APB_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [exec_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire exec_pkg::op_t instr_op,
	input wire logic [exec_pkg::DATA_W-1:0] instr_literal,
	input wire logic [exec_pkg::FILE_AW-1:0] file_addr,
	input wire logic [exec_pkg::DATA_W-1:0] file_rdata,
	input wire logic dest_bit,
	input wire logic [exec_pkg::IP_W-1:0] stack_head,
	output logic file_we,
	output logic [exec_pkg::FILE_AW-1:0] file_waddr,
	output logic [exec_pkg::DATA_W-1:0] file_wdata,
	output logic [exec_pkg::DATA_W-1:0] accumulator,
	output logic borrow_out_bit,
	output logic nibble_borrow_flag,
	output logic result_null_flag,
	output logic timeout_bit,
	output logic powerdown_bit,
	output logic [exec_pkg::IP_W-1:0] instr_pointer,
	output logic stack_pop,
	output logic prefetch_discard,
	output logic watchdog_clear,
	output logic prescaler_clear,
	output logic osc_halt
);
	typedef struct packed {
		logic [exec_pkg::DATA_W-1:0] acc;
		logic borrow;
		logic nibble;
		logic null_f;
		logic timeout;
		logic powerdown;
		logic [exec_pkg::IP_W-1:0] ip;
		logic [exec_pkg::DATA_W-1:0] result;
		logic file_we;
		logic [exec_pkg::FILE_AW-1:0] waddr;
		logic [exec_pkg::APB_DW-1:0] prdata;
		logic wake;
	} core_t;

	core_t core_ff;
	core_t nxt_core;
	logic accept;
	logic apb_setup;
	logic apb_write;

	alu_if alu_bus ();
	seq_if seq_bus ();

	function automatic logic addr_mapped(input logic [exec_pkg::APB_AW-1:0] a);
		case (a)
			exec_pkg::ADDR_ACC, exec_pkg::ADDR_STATUS,
			exec_pkg::ADDR_IP, exec_pkg::ADDR_CTRL: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction : addr_mapped

	exec_alu u_alu (
		.bus(alu_bus)
	);

	exec_seq u_seq (
		.clock(clock),
		.rst_b(rst_b),
		.bus(seq_bus)
	);

	assign accept = instr_valid && seq_bus.ready;
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite && addr_mapped(paddr);

	// File operand for file forms, literal otherwise
	assign alu_bus.op = instr_op;
	assign alu_bus.operand = exec_pkg::is_file_op(instr_op) ? file_rdata : instr_literal;
	assign alu_bus.acc = core_ff.acc;
	assign alu_bus.carry_in = core_ff.borrow;

	assign seq_bus.accept = accept;
	assign seq_bus.op = instr_op;
	assign seq_bus.wake = core_ff.wake;

	always_comb begin
		nxt_core = core_ff;
		nxt_core.file_we = 1'b0;
		nxt_core.wake = 1'b0;
		// Read data is latched in the setup phase
		if (apb_setup) begin
			nxt_core.prdata = exec_pkg::RST_PRDATA;
			case (paddr)
				exec_pkg::ADDR_ACC: nxt_core.prdata = 32'(core_ff.acc);
				exec_pkg::ADDR_STATUS: begin
					nxt_core.prdata[exec_pkg::ST_BORROW] = core_ff.borrow;
					nxt_core.prdata[exec_pkg::ST_NIBBLE] = core_ff.nibble;
					nxt_core.prdata[exec_pkg::ST_NULL] = core_ff.null_f;
					nxt_core.prdata[exec_pkg::ST_POWERDOWN] = core_ff.powerdown;
					nxt_core.prdata[exec_pkg::ST_TIMEOUT] = core_ff.timeout;
				end
				exec_pkg::ADDR_IP: nxt_core.prdata = 32'(core_ff.ip);
				exec_pkg::ADDR_CTRL: nxt_core.prdata[exec_pkg::CTRL_ASLEEP] = seq_bus.asleep;
				default: nxt_core.prdata = exec_pkg::RST_PRDATA;
			endcase
		end
		if (apb_write && pstrb[0]) begin
			case (paddr)
				exec_pkg::ADDR_ACC: nxt_core.acc = pwdata[exec_pkg::DATA_W-1:0];
				exec_pkg::ADDR_STATUS: begin
					nxt_core.borrow = pwdata[exec_pkg::ST_BORROW];
					nxt_core.nibble = pwdata[exec_pkg::ST_NIBBLE];
					nxt_core.null_f = pwdata[exec_pkg::ST_NULL];
				end
				exec_pkg::ADDR_CTRL: nxt_core.wake = pwdata[exec_pkg::CTRL_WAKE];
				default: nxt_core.wake = 1'b0;
			endcase
		end
		// Execution overrides a software write in the same cycle
		if (accept) begin
			case (instr_op)
				exec_pkg::op_idle: nxt_core.result = core_ff.result;
				exec_pkg::return_op: nxt_core.ip = stack_head;
				exec_pkg::sleep_op: begin
					nxt_core.powerdown = 1'b0;
					nxt_core.timeout = 1'b1;
				end
				default: begin
					nxt_core.result = alu_bus.result;
					if (alu_bus.upd_carry) begin
						nxt_core.borrow = alu_bus.carry_out;
					end
					if (alu_bus.upd_nibble) begin
						nxt_core.nibble = alu_bus.nibble_out;
					end
					if (alu_bus.upd_null) begin
						nxt_core.null_f = alu_bus.null_out;
					end
					if (exec_pkg::is_file_op(instr_op) && dest_bit) begin
						nxt_core.file_we = 1'b1;
						nxt_core.waddr = file_addr;
					end else begin
						nxt_core.acc = alu_bus.result;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			core_ff <= '{acc: exec_pkg::RST_ACC, borrow: exec_pkg::RST_FLAG,
				nibble: exec_pkg::RST_FLAG, null_f: exec_pkg::RST_FLAG,
				timeout: exec_pkg::RST_TIMEOUT, powerdown: exec_pkg::RST_POWERDOWN,
				ip: exec_pkg::RST_IP, result: exec_pkg::RST_ACC, file_we: 1'b0,
				waddr: '0, prdata: exec_pkg::RST_PRDATA, wake: 1'b0};
		end else begin
			core_ff <= nxt_core;
		end
	end

	assign prdata = core_ff.prdata;
	assign pready = psel && penable;
	assign pslverr = psel && penable && !addr_mapped(paddr);
	assign instr_ready = seq_bus.ready;
	assign file_we = core_ff.file_we;
	assign file_waddr = core_ff.waddr;
	assign file_wdata = core_ff.result;
	assign accumulator = core_ff.acc;
	assign borrow_out_bit = core_ff.borrow;
	assign nibble_borrow_flag = core_ff.nibble;
	assign result_null_flag = core_ff.null_f;
	assign timeout_bit = core_ff.timeout;
	assign powerdown_bit = core_ff.powerdown;
	assign instr_pointer = core_ff.ip;
	assign stack_pop = seq_bus.stack_pop;
	assign prefetch_discard = seq_bus.prefetch_discard;
	assign watchdog_clear = seq_bus.watchdog_clear;
	assign prescaler_clear = seq_bus.watchdog_clear;
	assign osc_halt = seq_bus.asleep;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_rotate_left_value: assert property (accept && instr_op == exec_pkg::rotate_left_thru_carry
		|=> file_wdata == {$past(file_rdata[6:0]), $past(borrow_out_bit)}
		&& borrow_out_bit == $past(file_rdata[7]))
		else $error("rotate left result or carry wrong");
	a_rotate_right_value: assert property (accept && instr_op == exec_pkg::rotate_right_thru_carry
		&& !apb_write |=> file_wdata == {$past(borrow_out_bit), $past(file_rdata[7:1])}
		&& borrow_out_bit == $past(file_rdata[0])
		&& $stable(result_null_flag) && $stable(nibble_borrow_flag))
		else $error("rotate right result or flags wrong");
	a_dest_select_file: assert property (accept && exec_pkg::is_file_op(instr_op) && dest_bit
		&& !apb_write |=> file_we && file_waddr == $past(file_addr) && $stable(accumulator))
		else $error("file destination not written");
	a_dest_select_acc: assert property (accept && exec_pkg::is_file_op(instr_op) && !dest_bit
		|=> !file_we && accumulator == file_wdata)
		else $error("accumulator destination not written");
	a_sleep_status_bits: assert property (accept && instr_op == exec_pkg::sleep_op && !apb_write
		|=> !powerdown_bit && timeout_bit && $stable(borrow_out_bit) && $stable(result_null_flag)
		&& prescaler_clear)
		else $error("sleep status bits wrong");
	a_return_ip_load: assert property (accept && instr_op == exec_pkg::return_op && !apb_write
		|=> instr_pointer == $past(stack_head) && stack_pop && $stable(borrow_out_bit)
		&& $stable(result_null_flag))
		else $error("return did not load stack head");
	a_literal_sub_value: assert property (accept && instr_op == exec_pkg::literal_minus_acc_op
		|=> accumulator == 8'($past(instr_literal) - $past(accumulator))
		&& borrow_out_bit == ($past(instr_literal) >= $past(accumulator)))
		else $error("literal subtract wrong");
	a_file_sub_flags: assert property (accept && instr_op == exec_pkg::file_minus_acc_op
		|=> file_wdata == 8'($past(file_rdata) - $past(accumulator))
		&& nibble_borrow_flag == ($past(file_rdata[3:0]) >= $past(accumulator[3:0])))
		else $error("file subtract wrong");
	a_nibble_swap: assert property (accept && instr_op == exec_pkg::nibble_exchange_op && !apb_write
		|=> file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
		&& $stable(borrow_out_bit) && $stable(result_null_flag))
		else $error("nibble exchange wrong");
	a_literal_xor: assert property (accept && instr_op == exec_pkg::literal_xor_acc_op && !apb_write
		|=> accumulator == ($past(instr_literal) ^ $past(accumulator)) && $stable(borrow_out_bit))
		else $error("literal xor wrong");
	a_file_xor: assert property (accept && instr_op == exec_pkg::file_xor_acc_op && !apb_write
		|=> file_wdata == ($past(file_rdata) ^ $past(accumulator)) && $stable(nibble_borrow_flag))
		else $error("file xor wrong");
	a_null_single_cycle: assert property (accept && alu_bus.upd_null
		&& instr_op != exec_pkg::sleep_op |=> result_null_flag == (file_wdata == 8'h00)
		&& instr_ready)
		else $error("null flag or single cycle wrong");

endmodule : cpu_execute_rotate_sub_xor_sleep

// [cpu_execute_rotate_sub_xor_sleep_tb_top.sv]
`timescale 1ns/1ps

module cpu_execute_rotate_sub_xor_sleep_tb_top;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [exec_pkg::APB_AW-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, instr_ready, file_we, borrow_out_bit, nibble_borrow_flag;
	logic result_null_flag, timeout_bit, powerdown_bit, stack_pop, prefetch_discard;
	logic watchdog_clear, prescaler_clear, osc_halt;
	logic instr_valid = 1'b0;
	exec_pkg::op_t instr_op = exec_pkg::op_idle;
	logic [7:0] instr_literal = 8'h00;
	logic [6:0] file_addr = 7'h00;
	logic [7:0] file_rdata, file_wdata, accumulator;
	logic dest_bit = 1'b0;
	logic [12:0] stack_head, instr_pointer;
	logic [6:0] file_waddr;
	int n_mismatch = 0;
	int n_checks = 0;

	always #50 clock = ~clock;

	cpu_execute_rotate_sub_xor_sleep dut_u (.clock(clock), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .instr_op(instr_op), .instr_literal(instr_literal),
		.file_addr(file_addr), .file_rdata(file_rdata), .dest_bit(dest_bit),
		.stack_head(stack_head), .file_we(file_we), .file_waddr(file_waddr),
		.file_wdata(file_wdata), .accumulator(accumulator), .borrow_out_bit(borrow_out_bit),
		.nibble_borrow_flag(nibble_borrow_flag), .result_null_flag(result_null_flag),
		.timeout_bit(timeout_bit), .powerdown_bit(powerdown_bit),
		.instr_pointer(instr_pointer), .stack_pop(stack_pop),
		.prefetch_discard(prefetch_discard), .watchdog_clear(watchdog_clear),
		.prescaler_clear(prescaler_clear), .osc_halt(osc_halt));

	file_stack_model model_u (.clock(clock), .rst_b(rst_b), .file_addr(file_addr),
		.file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
		.file_wdata(file_wdata), .stack_head(stack_head), .stack_pop(stack_pop));

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic wr_en, input logic [11:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= addr;
		pwdata <= wd;
		pstrb <= 4'hf;
		penable <= 1'b0;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
		logic [31:0] r;
		logic e;
		apb(1'b1, addr, wd, r, e);
	endtask : wr

	task automatic issue(input exec_pkg::op_t op, input logic [7:0] lit,
		input logic [6:0] fa, input logic d);
		@(posedge clock);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_literal <= lit;
		file_addr <= fa;
		dest_bit <= d;
		do begin
			@(posedge clock);
		end while (instr_ready !== 1'b1);
		instr_valid <= 1'b0;
		instr_op <= exec_pkg::op_idle;
		@(negedge clock);
	endtask : issue

	// Carry set means no borrow: {nibble carry, carry, difference}
	function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] d;
		d = a - b;
		return {a[3:0] >= b[3:0], a >= b, d};
	endfunction : sub8

	task automatic t_apb;
		logic [31:0] r;
		logic e;
		wr(exec_pkg::ADDR_ACC, 32'h0000_005a);
		apb(1'b0, exec_pkg::ADDR_ACC, 32'h0000_0000, r, e);
		chk("acc readback", r, 32'h0000_005a);
		apb(1'b0, 12'h010, 32'h0000_0000, r, e);
		chk("unmapped error", 32'(e), 32'h0000_0001);
		chk("unmapped data", r, 32'h0000_0000);
	endtask : t_apb

	task automatic t_rot;
		wr(exec_pkg::ADDR_STATUS, 32'h0000_0004);
		model_u.mem[5] = 8'h81;
		model_u.mem[6] = 8'h02;
		issue(exec_pkg::rotate_left_thru_carry, 8'h00, 7'h05, 1'b1);
		chk("rotl data", 32'(file_wdata), 32'h0000_0002);
		chk("rotl carry", 32'(borrow_out_bit), 32'h0000_0001);
		chk("rotl we", 32'(file_we), 32'h0000_0001);
		chk("rotl addr", 32'(file_waddr), 32'h0000_0005);
		issue(exec_pkg::rotate_right_thru_carry, 8'h00, 7'h06, 1'b0);
		chk("rotr acc", 32'(accumulator), 32'h0000_0081);
		chk("rotr carry", 32'(borrow_out_bit), 32'h0000_0000);
		chk("rotr null", 32'(result_null_flag), 32'h0000_0001);
		chk("rotr we", 32'(file_we), 32'h0000_0000);
		chk("rotl file", 32'(model_u.mem[5]), 32'h0000_0002);
	endtask : t_rot

	task automatic t_sub;
		logic [7:0] ks [4] = '{8'h05, 8'h00, 8'h10, 8'hff};
		logic [7:0] ws [4] = '{8'h05, 8'h01, 8'h01, 8'h00};
		logic [9:0] e;
		for (int i = 0; i < 4; i++) begin
			wr(exec_pkg::ADDR_ACC, 32'(ws[i]));
			issue(exec_pkg::literal_minus_acc_op, ks[i], 7'h00, 1'b0);
			e = sub8(ks[i], ws[i]);
			chk("subl acc", 32'(accumulator), 32'(e[7:0]));
			chk("subl borrow", 32'(borrow_out_bit), 32'(e[8]));
			chk("subl nibble", 32'(nibble_borrow_flag), 32'(e[9]));
			chk("subl null", 32'(result_null_flag), 32'(e[7:0] == 8'h00));
		end
		model_u.mem[127] = 8'h20;
		wr(exec_pkg::ADDR_ACC, 32'h0000_0021);
		issue(exec_pkg::file_minus_acc_op, 8'h00, 7'h7f, 1'b1);
		chk("subf data", 32'(file_wdata), 32'h0000_00ff);
		chk("subf addr", 32'(file_waddr), 32'h0000_007f);
		chk("subf acc", 32'(accumulator), 32'h0000_0021);
		chk("subf flags", 32'({nibble_borrow_flag, borrow_out_bit}), 32'h0000_0000);
	endtask : t_sub

	task automatic t_swap_xor;
		model_u.mem[1] = 8'ha5;
		model_u.mem[2] = 8'h3c;
		wr(exec_pkg::ADDR_STATUS, 32'h0000_0007);
		issue(exec_pkg::nibble_exchange_op, 8'h00, 7'h01, 1'b0);
		chk("swap acc", 32'(accumulator), 32'h0000_005a);
		chk("swap flags", 32'({result_null_flag, nibble_borrow_flag, borrow_out_bit}),
			32'h0000_0007);
		chk("single cycle", 32'(instr_ready), 32'h0000_0001);
		issue(exec_pkg::literal_xor_acc_op, 8'h0f, 7'h01, 1'b0);
		chk("xorl acc", 32'(accumulator), 32'h0000_0055);
		chk("xorl flags", 32'({result_null_flag, nibble_borrow_flag, borrow_out_bit}),
			32'h0000_0003);
		issue(exec_pkg::literal_xor_acc_op, 8'h55, 7'h01, 1'b0);
		chk("xorl zero", 32'(result_null_flag), 32'h0000_0001);
		issue(exec_pkg::file_xor_acc_op, 8'h00, 7'h02, 1'b1);
		chk("xorf data", 32'(file_wdata), 32'h0000_003c);
		chk("xorf we", 32'(file_we), 32'h0000_0001);
		chk("xorf null", 32'(result_null_flag), 32'h0000_0000);
		chk("xorf acc", 32'(accumulator), 32'h0000_0000);
		@(negedge clock);
		chk("xorf we end", 32'(file_we), 32'h0000_0000);
	endtask : t_swap_xor

	task automatic t_ret;
		model_u.stk[7] = 13'h1abc;
		model_u.stk[6] = 13'h0123;
		wr(exec_pkg::ADDR_STATUS, 32'h0000_0002);
		issue(exec_pkg::return_op, 8'h00, 7'h00, 1'b0);
		chk("ret ip", 32'(instr_pointer), 32'h0000_1abc);
		chk("ret pop", 32'(stack_pop), 32'h0000_0001);
		chk("ret flush", 32'(prefetch_discard), 32'h0000_0001);
		chk("ret busy", 32'(instr_ready), 32'h0000_0000);
		chk("ret flags", 32'({result_null_flag, nibble_borrow_flag, borrow_out_bit}),
			32'h0000_0002);
		@(negedge clock);
		chk("ret free", 32'(instr_ready), 32'h0000_0001);
		chk("ret pop end", 32'(stack_pop), 32'h0000_0000);
		issue(exec_pkg::return_op, 8'h00, 7'h00, 1'b0);
		chk("ret2 ip", 32'(instr_pointer), 32'h0000_0123);
	endtask : t_ret

	task automatic t_sleep;
		logic [31:0] r;
		logic e;
		int n;
		wr(exec_pkg::ADDR_STATUS, 32'h0000_0005);
		issue(exec_pkg::sleep_op, 8'h00, 7'h00, 1'b0);
		chk("sleep powerdown", 32'(powerdown_bit), 32'h0000_0000);
		chk("sleep timeout", 32'(timeout_bit), 32'h0000_0001);
		chk("sleep flags", 32'({result_null_flag, nibble_borrow_flag, borrow_out_bit}),
			32'h0000_0005);
		chk("wd clear", 32'({watchdog_clear, prescaler_clear}), 32'h0000_0003);
		chk("halt", 32'({osc_halt, instr_ready}), 32'h0000_0002);
		@(negedge clock);
		chk("wd clear end", 32'({watchdog_clear, prescaler_clear}), 32'h0000_0000);
		apb(1'b0, exec_pkg::ADDR_CTRL, 32'h0000_0000, r, e);
		chk("asleep", 32'(r[1]), 32'h0000_0001);
		chk("still halted", 32'(osc_halt), 32'h0000_0001);
		apb(1'b0, exec_pkg::ADDR_STATUS, 32'h0000_0000, r, e);
		chk("status read", r, 32'h0000_0015);
		apb(1'b0, exec_pkg::ADDR_IP, 32'h0000_0000, r, e);
		chk("ip read", r, 32'h0000_0123);
		wr(exec_pkg::ADDR_CTRL, 32'h0000_0001);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (instr_ready !== 1'b1 && n < 10);
		chk("woken", 32'({osc_halt, instr_ready}), 32'h0000_0001);
	endtask : t_sleep

	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(negedge clock);
		chk("reset timeout/powerdown", 32'({timeout_bit, powerdown_bit}), 32'h0000_0003);
		chk("reset ready", 32'(instr_ready), 32'h0000_0001);
		t_apb();
		t_rot();
		t_sub();
		t_swap_xor();
		t_ret();
		t_sleep();
		summarize();
	end

	initial begin
		repeat (3000) @(posedge clock);
		n_mismatch++;
		summarize();
	end
endmodule : cpu_execute_rotate_sub_xor_sleep_tb_top

// [exec_alu.sv]
`timescale 1ns/1ps

module exec_alu (
	alu_if.alu bus
);
	// Returns {no_borrow, nibble_no_borrow, difference} of a minus b
	function automatic logic [exec_pkg::DATA_W+1:0] sub8(
		input logic [exec_pkg::DATA_W-1:0] a,
		input logic [exec_pkg::DATA_W-1:0] b
	);
		logic [exec_pkg::DATA_W:0] full;
		logic [exec_pkg::NIBBLE_W:0] low;
		full = {1'b0, a} + {1'b0, ~b} + 9'h001;
		low = {1'b0, a[exec_pkg::NIBBLE_W-1:0]} + {1'b0, ~b[exec_pkg::NIBBLE_W-1:0]} + 5'h01;
		sub8 = {full[exec_pkg::DATA_W], low[exec_pkg::NIBBLE_W], full[exec_pkg::DATA_W-1:0]};
	endfunction : sub8

	always_comb begin
		logic [exec_pkg::DATA_W+1:0] diff;
		diff = sub8(bus.operand, bus.acc);
		bus.result = bus.acc;
		bus.carry_out = bus.carry_in;
		bus.nibble_out = 1'b0;
		bus.upd_carry = 1'b0;
		bus.upd_nibble = 1'b0;
		bus.upd_null = 1'b0;
		case (bus.op)
			exec_pkg::rotate_left_thru_carry: begin
				{bus.carry_out, bus.result} = {bus.operand, bus.carry_in};
				bus.upd_carry = 1'b1;
			end
			exec_pkg::rotate_right_thru_carry: begin
				{bus.result, bus.carry_out} = {bus.carry_in, bus.operand};
				bus.upd_carry = 1'b1;
			end
			exec_pkg::literal_minus_acc_op, exec_pkg::file_minus_acc_op: begin
				{bus.carry_out, bus.nibble_out, bus.result} = diff;
				bus.upd_carry = 1'b1;
				bus.upd_nibble = 1'b1;
				bus.upd_null = 1'b1;
			end
			exec_pkg::nibble_exchange_op: begin
				bus.result = {bus.operand[exec_pkg::NIBBLE_W-1:0],
					bus.operand[exec_pkg::DATA_W-1:exec_pkg::NIBBLE_W]};
			end
			exec_pkg::literal_xor_acc_op, exec_pkg::file_xor_acc_op: begin
				bus.result = bus.operand ^ bus.acc;
				bus.upd_null = 1'b1;
			end
			default: begin
				bus.result = bus.acc;
			end
		endcase
		bus.null_out = (bus.result == 8'h00);
	end

endmodule : exec_alu

// [exec_if.sv]
`timescale 1ns/1ps

interface alu_if;
	exec_pkg::op_t op;
	logic [exec_pkg::DATA_W-1:0] operand;
	logic [exec_pkg::DATA_W-1:0] acc;
	logic carry_in;
	logic [exec_pkg::DATA_W-1:0] result;
	logic carry_out;
	logic nibble_out;
	logic null_out;
	logic upd_carry;
	logic upd_nibble;
	logic upd_null;

	modport alu (input op, operand, acc, carry_in,
		output result, carry_out, nibble_out, null_out, upd_carry, upd_nibble, upd_null);
	modport core (output op, operand, acc, carry_in,
		input result, carry_out, nibble_out, null_out, upd_carry, upd_nibble, upd_null);
endinterface : alu_if

interface seq_if;
	logic accept;
	exec_pkg::op_t op;
	logic wake;
	logic ready;
	logic stack_pop;
	logic prefetch_discard;
	logic watchdog_clear;
	logic asleep;

	modport seq (input accept, op, wake,
		output ready, stack_pop, prefetch_discard, watchdog_clear, asleep);
	modport core (output accept, op, wake,
		input ready, stack_pop, prefetch_discard, watchdog_clear, asleep);
endinterface : seq_if

// [exec_pkg.sv]
package exec_pkg;

	localparam int DATA_W = 8;
	localparam int NIBBLE_W = 4;
	localparam int IP_W = 13;
	localparam int FILE_AW = 7;
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;

	// Instruction codes presented by the decoder
	typedef enum logic [3:0] {
		op_idle,
		rotate_left_thru_carry,
		rotate_right_thru_carry,
		literal_minus_acc_op,
		file_minus_acc_op,
		nibble_exchange_op,
		literal_xor_acc_op,
		file_xor_acc_op,
		return_op,
		sleep_op
	} op_t;

	typedef enum logic [1:0] {
		st_run,
		st_flush,
		st_sleep
	} seq_state_t;

	// Register word addresses
	localparam logic [APB_AW-1:0] ADDR_ACC = 12'h000;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;
	localparam logic [APB_AW-1:0] ADDR_IP = 12'h008;
	localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h00c;

	// Status word bit positions
	localparam int ST_BORROW = 0;
	localparam int ST_NIBBLE = 1;
	localparam int ST_NULL = 2;
	localparam int ST_POWERDOWN = 3;
	localparam int ST_TIMEOUT = 4;

	// Control word bit positions
	localparam int CTRL_WAKE = 0;
	localparam int CTRL_ASLEEP = 1;

	// Reset values
	localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
	localparam logic [IP_W-1:0] RST_IP = 13'h0000;
	localparam logic RST_FLAG = 1'b0;
	localparam logic RST_TIMEOUT = 1'b1;
	localparam logic RST_POWERDOWN = 1'b1;
	localparam logic [APB_DW-1:0] RST_PRDATA = 32'h0000_0000;

	function automatic logic is_file_op(input op_t op);
		case (op)
			rotate_left_thru_carry, rotate_right_thru_carry, file_minus_acc_op,
			nibble_exchange_op, file_xor_acc_op: is_file_op = 1'b1;
			default: is_file_op = 1'b0;
		endcase
	endfunction : is_file_op

endpackage : exec_pkg

// [exec_seq.sv]
`timescale 1ns/1ps

module exec_seq (
	input wire logic clock,
	input wire logic rst_b,
	seq_if.seq bus
);
	typedef struct packed {
		exec_pkg::seq_state_t state;
		logic pop;
		logic wd_clr;
	} seq_q_t;

	seq_q_t seq_ff;
	seq_q_t nxt_seq;

	always_comb begin
		nxt_seq = seq_ff;
		nxt_seq.pop = 1'b0;
		nxt_seq.wd_clr = 1'b0;
		case (seq_ff.state)
			exec_pkg::st_run: begin
				if (bus.accept && bus.op == exec_pkg::return_op) begin
					nxt_seq.state = exec_pkg::st_flush;
					nxt_seq.pop = 1'b1;
				end else if (bus.accept && bus.op == exec_pkg::sleep_op) begin
					nxt_seq.state = exec_pkg::st_sleep;
					nxt_seq.wd_clr = 1'b1;
				end
			end
			exec_pkg::st_flush: begin
				nxt_seq.state = exec_pkg::st_run;
			end
			exec_pkg::st_sleep: begin
				if (bus.wake) begin
					nxt_seq.state = exec_pkg::st_run;
				end
			end
			default: begin
				nxt_seq.state = exec_pkg::st_run;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			seq_ff <= '{state: exec_pkg::st_run, pop: 1'b0, wd_clr: 1'b0};
		end else begin
			seq_ff <= nxt_seq;
		end
	end

	assign bus.ready = (seq_ff.state == exec_pkg::st_run);
	assign bus.stack_pop = seq_ff.pop;
	assign bus.prefetch_discard = (seq_ff.state == exec_pkg::st_flush);
	assign bus.watchdog_clear = seq_ff.wd_clr;
	assign bus.asleep = (seq_ff.state == exec_pkg::st_sleep);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence ret_taken;
		bus.accept && bus.op == exec_pkg::return_op;
	endsequence
	sequence ret_flushed;
		!bus.ready && bus.prefetch_discard && bus.stack_pop ##1 bus.ready && !bus.stack_pop;
	endsequence
	sequence sleep_taken;
		bus.accept && bus.op == exec_pkg::sleep_op;
	endsequence

	a_return_two_cycles: assert property (ret_taken |=> ret_flushed)
		else $error("return did not take exactly two cycles");
	a_sleep_wdt_clear: assert property (sleep_taken |=> bus.watchdog_clear ##1 !bus.watchdog_clear)
		else $error("watchdog clear pulse missing after sleep");
	a_sleep_halt_held: assert property (sleep_taken |=> bus.asleep [*2] or (bus.asleep ##1 $past(bus.wake)))
		else $error("sleep state not entered or left without wake");
	a_sleep_stays: assert property (bus.asleep && !bus.wake |=> bus.asleep && !bus.ready)
		else $error("sleep left without wake request");

endmodule : exec_seq

// [file_stack_model.sv]
`timescale 1ns/1ps

module file_stack_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [exec_pkg::FILE_AW-1:0] file_addr,
	output logic [exec_pkg::DATA_W-1:0] file_rdata,
	input wire logic file_we,
	input wire logic [exec_pkg::FILE_AW-1:0] file_waddr,
	input wire logic [exec_pkg::DATA_W-1:0] file_wdata,
	output logic [exec_pkg::IP_W-1:0] stack_head,
	input wire logic stack_pop
);
	logic [exec_pkg::DATA_W-1:0] mem [0:127];
	logic [exec_pkg::IP_W-1:0] stk [0:7];
	logic [2:0] sp_ff;

	// Operand appears in the same cycle as its address
	assign file_rdata = mem[file_addr];
	assign stack_head = stk[sp_ff];

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sp_ff <= 3'h7;
		end else if (stack_pop) begin
			sp_ff <= sp_ff - 3'h1;
		end
	end

	always @(posedge clock) begin
		if (file_we === 1'b1) begin
			mem[file_waddr] <= file_wdata;
		end
	end
endmodule : file_stack_model
